// ### verilog/sfcf_frontend.sv
`timescale 1ns/10ps
`default_nettype none
module sfcf_frontend
    import sfcf_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        resetn,
    input  wire logic        chip_select_n,
    input  wire logic        serial_clk,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             serial_out_en,
    input  wire logic        array_busy,
    input  wire logic [7:0]  param_rdata,
    output logic [23:0]      param_addr,
    output logic             op_valid,
    output logic [7:0]       op_code,
    output logic [23:0]      op_addr,
    output logic             data_valid,
    output logic [7:0]       data_byte,
    input  wire logic        data_ready,
    output logic             write_enable_latch,
    output logic             powered_down,
    output logic [7:0]       status_one,
    output logic [7:0]       status_two,
    output logic [7:0]       status_three
);
    logic [2:0]  csn_sync_r;
    logic [2:0]  clk_sync_r;
    logic [1:0]  din_sync_r;
    logic        rise;
    logic        fall;
    logic        frame_end;
    logic        frame_start;
    sfcf_state_e state_r;
    logic [7:0]  sh_r;
    logic [2:0]  bit_r;
    logic [7:0]  opc_r;
    logic [7:0]  nbyte_r;
    logic [23:0] addr_r;
    logic [7:0]  out_r;
    logic [2:0]  obit_r;
    logic        vol_en_r;
    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_clr;
    logic        prot;
    logic [7:0]  byte_in;
    logic        byte_done;
    logic        is_write;
    logic        is_pgm;
    logic        is_erase;
    logic        commit_ok;
    logic [7:0]  sr_hold_r [3];
    logic [7:0]  out_src;
    logic [7:0]  sr1_view;
    logic        fifo_out_valid;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            csn_sync_r <= 3'h7;
            clk_sync_r <= 3'h0;
            din_sync_r <= 2'h0;
        end else begin
            csn_sync_r <= {csn_sync_r[1:0], chip_select_n};
            clk_sync_r <= {clk_sync_r[1:0], serial_clk};
            din_sync_r <= {din_sync_r[0], serial_in};
        end
    end
    assign rise        = clk_sync_r[1] && !clk_sync_r[2] && !csn_sync_r[1];
    assign fall        = !clk_sync_r[1] && clk_sync_r[2] && !csn_sync_r[1];
    assign frame_end   = csn_sync_r[1] && !csn_sync_r[2];
    assign frame_start = !csn_sync_r[1] && csn_sync_r[2];
    assign byte_in     = {sh_r[6:0], din_sync_r[1]};
    assign byte_done   = rise && (bit_r == 3'h7);

    assign is_pgm   = (opc_r == OP_PGM) || (opc_r == OP_QPGM);
    assign is_erase = (opc_r == OP_SECE) || (opc_r == OP_HBLE) || (opc_r == OP_BLKE);
    assign is_write = is_pgm || is_erase || (opc_r == OP_WRS1) || (opc_r == OP_WRS2)
                   || (opc_r == OP_WRS3A) || (opc_r == OP_WRS3B);

    sfcf_protect u_prot (
        .protect_complement    (status_two[SR2_CMP]),
        .small_granule_protect (status_three[SR3_GRAN]),
        .top_bottom            (status_one[SR1_TB]),
        .protect_field         (status_one[SR1_BP0+2:SR1_BP0]),
        .addr                  (addr_r),
        .is_protected          (prot)
    );

    // whole-byte, length, latch, busy and protection checks at frame end
    always_comb begin
        commit_ok = (bit_r == 3'h0);
        if (is_pgm && nbyte_r < 8'd4) commit_ok = 1'b0;
        if (is_erase && nbyte_r != 8'd3) commit_ok = 1'b0;
        if (array_busy) commit_ok = 1'b0;
        if (!write_enable_latch && !(vol_en_r && opc_r == OP_WRS1)) commit_ok = 1'b0;
        if ((is_pgm || is_erase) && prot) commit_ok = 1'b0;
        if (powered_down) commit_ok = 1'b0;
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            state_r <= ST_IGN;
            sh_r    <= 8'h00;
            bit_r   <= 3'h0;
            opc_r   <= 8'h00;
            nbyte_r <= 8'h00;
            addr_r  <= 24'h000000;
        end else if (frame_start) begin
            state_r <= ST_OPC;
            bit_r   <= 3'h0;
            nbyte_r <= 8'h00;
            opc_r   <= 8'h00;
        end else if (rise) begin
            sh_r  <= byte_in;
            bit_r <= bit_r + 3'h1;
            if (byte_done) begin
                case (state_r)
                    ST_OPC: begin
                        opc_r <= byte_in;
                        if (powered_down && byte_in != OP_WAKE) state_r <= ST_IGN;
                        else begin
                            case (byte_in)
                                OP_RDS1, OP_RDS2A, OP_RDS2B, OP_RDS3A, OP_RDS3B:
                                    state_r <= ST_OUT;
                                OP_WAKE: state_r <= ST_DUMM;
                                OP_SFDP, OP_PGM, OP_QPGM, OP_SECE, OP_HBLE, OP_BLKE:
                                    state_r <= ST_ADDR;
                                OP_WRS1, OP_WRS2, OP_WRS3A, OP_WRS3B:
                                    state_r <= ST_DATA;
                                OP_WREN, OP_WRITE_DISABLE_CMD, OP_VWREN, OP_DPD: state_r <= ST_DATA;
                                default: state_r <= ST_IGN;
                            endcase
                        end
                    end
                    ST_ADDR: begin
                        nbyte_r <= nbyte_r + 8'd1;
                        addr_r  <= {addr_r[15:0], byte_in};
                        if (nbyte_r == 8'd2) state_r <= (opc_r == OP_SFDP) ? ST_DUMM : ST_DATA;
                    end
                    ST_DUMM: begin
                        nbyte_r <= nbyte_r + 8'd1;
                        if (opc_r == OP_SFDP || nbyte_r == 8'd2) state_r <= ST_OUT;
                    end
                    ST_DATA: begin
                        nbyte_r <= (nbyte_r == 8'hFF) ? nbyte_r : nbyte_r + 8'd1;
                    end
                    ST_OUT:  state_r <= ST_OUT;
                    ST_IGN:  state_r <= ST_IGN;
                    default: state_r <= ST_IGN;
                endcase
            end
        end else if (frame_end) begin
            state_r <= ST_IGN;
        end
    end

    // status and latch updates at frame end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            write_enable_latch <= 1'b0;
            vol_en_r           <= 1'b0;
            powered_down       <= 1'b0;
            status_one         <= SR1_RST;
        end else if (frame_end && state_r != ST_IGN) begin
            vol_en_r <= 1'b0;
            if (bit_r == 3'h0 && state_r == ST_DATA && !array_busy) begin
                case (opc_r)
                    OP_WREN:  write_enable_latch <= 1'b1;
                    OP_WRITE_DISABLE_CMD:  write_enable_latch <= 1'b0;
                    OP_VWREN: vol_en_r <= 1'b1;
                    OP_DPD:   powered_down <= !powered_down ? 1'b1 : powered_down;
                    default:  vol_en_r <= 1'b0;
                endcase
            end
            if (opc_r == OP_WAKE && nbyte_r >= 8'd3) powered_down <= 1'b0;
            if (is_write && commit_ok) begin
                write_enable_latch <= 1'b0;
                if (opc_r == OP_WRS1) begin
                    if (nbyte_r >= 8'd1) status_one <= sr_hold_r[0];
                end
            end
        end
    end

    // status bytes captured per data byte for status writes
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            sr_hold_r[0] <= 8'h00;
            sr_hold_r[1] <= 8'h00;
            sr_hold_r[2] <= 8'h00;
        end else if (byte_done && state_r == ST_DATA && nbyte_r < 8'd3) begin
            sr_hold_r[nbyte_r[1:0]] <= byte_in;
        end
    end
    logic [7:0] s2_nxt;
    logic [7:0] s3_nxt;
    logic       s2_we;
    logic       s3_we;
    always_comb begin
        s2_nxt = sr_hold_r[0];
        s3_nxt = sr_hold_r[0];
        s2_we  = 1'b0;
        s3_we  = 1'b0;
        if (frame_end && state_r == ST_DATA && is_write && commit_ok) begin
            if (opc_r == OP_WRS1) begin
                s2_nxt = sr_hold_r[1];
                s3_nxt = sr_hold_r[2];
                s2_we  = nbyte_r >= 8'd2;
                s3_we  = nbyte_r >= 8'd3;
            end else if (nbyte_r == 8'd1) begin
                s2_we = (opc_r == OP_WRS2);
                s3_we = (opc_r == OP_WRS3A) || (opc_r == OP_WRS3B);
            end
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            status_two   <= SR2_RST;
            status_three <= SR3_RST;
        end else begin
            if (s2_we) status_two <= s2_nxt;
            if (s3_we) status_three <= s3_nxt;
        end
    end

    // array command issue and program data path
    assign fifo_in_valid = byte_done && state_r == ST_DATA && is_pgm;
    assign fifo_clr      = frame_start;
    sfcf_fifo #(.W(FIFO_WIDTH), .D(FIFO_DEPTH)) u_fifo (
        .mclk      (mclk),
        .resetn    (resetn),
        .clr       (fifo_clr),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (byte_in),
        .out_valid (fifo_out_valid),
        .out_ready (data_ready && op_valid),
        .out_data  (data_byte)
    );
    // data offered only once the command is accepted
    assign data_valid = fifo_out_valid && op_valid;
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            op_valid <= 1'b0;
            op_code  <= 8'h00;
            op_addr  <= 24'h000000;
        end else if (frame_end && state_r == ST_DATA && (is_pgm || is_erase) && commit_ok) begin
            op_valid <= 1'b1;
            op_code  <= opc_r;
            op_addr  <= addr_r;
        end else if (!data_valid || frame_start) begin
            op_valid <= 1'b0;
        end
    end

    // read-out byte source, latch shown in its status bit
    always_comb begin
        sr1_view          = status_one;
        sr1_view[SR1_WEL] = write_enable_latch;
        case (opc_r)
            OP_RDS1:            out_src = sr1_view;
            OP_RDS2A, OP_RDS2B: out_src = status_two;
            OP_RDS3A, OP_RDS3B: out_src = status_three;
            OP_WAKE:            out_src = DEV_ID;
            default:            out_src = param_rdata;
        endcase
    end

    // read-out shifter
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            out_r         <= 8'h00;
            obit_r        <= 3'h0;
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
            param_addr    <= 24'h000000;
        end else if (state_r != ST_OUT || csn_sync_r[1]) begin
            obit_r        <= 3'h0;
            serial_out_en <= 1'b0;
            param_addr    <= addr_r;
            out_r         <= out_src;
        end else if (fall) begin
            serial_out_en <= 1'b1;
            serial_out    <= out_r[3'h7 - obit_r];
            obit_r        <= obit_r + 3'h1;
            // next address presented seven bits ahead of its reload
            if (obit_r == 3'h0) param_addr <= param_addr + 24'h000001;
            if (obit_r == 3'h7) out_r <= out_src;
        end else if (!serial_out_en) begin
            // opcode known only now: reload before the first bit
            out_r <= out_src;
        end
    end

    AST_FIFO_NOT_OVER: assert property (@(posedge mclk) disable iff (!resetn)
        fifo_in_valid |-> fifo_in_ready) else $error("program fifo overflow");
    AST_LATCH_CLR: assert property (@(posedge mclk) disable iff (!resetn)
        (frame_end && is_write && commit_ok && state_r == ST_DATA)
        |=> !write_enable_latch) else $error("latch not cleared");
    AST_NO_OP_UNLATCHED: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(op_valid) |-> $past(write_enable_latch)) else $error("op without latch");
    AST_ERASE_LEN: assert property (@(posedge mclk) disable iff (!resetn)
        ($rose(op_valid) && op_code == OP_SECE) |-> $past(nbyte_r) == 8'd3)
        else $error("erase length wrong");
    AST_PGM_LEN: assert property (@(posedge mclk) disable iff (!resetn)
        ($rose(op_valid) && op_code == OP_PGM) |-> $past(nbyte_r) >= 8'd4)
        else $error("program too short");
    AST_BYTE_ALIGN: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(op_valid) |-> $past(bit_r) == 3'h0) else $error("partial byte accepted");
    AST_BUSY: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(op_valid) |-> !$past(array_busy)) else $error("op during busy");
    AST_PROT: assert property (@(posedge mclk) disable iff (!resetn)
        $rose(op_valid) |-> !$past(prot)) else $error("protected target accepted");
endmodule : sfcf_frontend
`default_nettype wire

// ### verilog/sfcf_pkg.sv
`default_nettype none
package sfcf_pkg;
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_WRITE_DISABLE_CMD   = 8'h04;
    localparam logic [7:0] OP_VWREN  = 8'h50;
    localparam logic [7:0] OP_RDS1   = 8'h05;
    localparam logic [7:0] OP_RDS2A  = 8'h09;
    localparam logic [7:0] OP_RDS2B  = 8'h35;
    localparam logic [7:0] OP_RDS3A  = 8'h95;
    localparam logic [7:0] OP_RDS3B  = 8'h15;
    localparam logic [7:0] OP_WRS1   = 8'h01;
    localparam logic [7:0] OP_WRS2   = 8'h31;
    localparam logic [7:0] OP_WRS3A  = 8'hC0;
    localparam logic [7:0] OP_WRS3B  = 8'h11;
    localparam logic [7:0] OP_WAKE   = 8'hAB;
    localparam logic [7:0] OP_SFDP   = 8'h5A;
    localparam logic [7:0] OP_PGM    = 8'h02;
    localparam logic [7:0] OP_QPGM   = 8'h32;
    localparam logic [7:0] OP_SECE   = 8'h20;
    localparam logic [7:0] OP_HBLE   = 8'h52;
    localparam logic [7:0] OP_BLKE   = 8'hD8;
    localparam logic [7:0] OP_DPD    = 8'hB9;
    localparam logic [7:0] DEV_ID    = 8'h5C; // arbitrary identifier value
    localparam logic [7:0] SR1_RST   = 8'h00;
    localparam logic [7:0] SR2_RST   = 8'h00;
    localparam logic [7:0] SR3_RST   = 8'h00;
    localparam int         SR1_WEL   = 1;
    localparam int         SR1_BP0   = 2;
    localparam int         SR1_TB    = 5;
    localparam int         SR2_CMP   = 6;
    localparam int         SR3_GRAN  = 0;
    localparam logic [4:0] ADDR_BITS_END = 5'd31;
    localparam int         FIFO_DEPTH = 8;
    localparam int         FIFO_WIDTH = 8;

    typedef enum logic [5:0] {
        ST_OPC  = 6'b000001,
        ST_ADDR = 6'b000010,
        ST_DATA = 6'b000100,
        ST_OUT  = 6'b001000,
        ST_DUMM = 6'b010000,
        ST_IGN  = 6'b100000
    } sfcf_state_e;

    typedef struct packed {
        logic       commit;
        logic [7:0] opcode;
        logic [23:0] addr;
        logic [7:0] nbytes;
    } sfcf_cmd_s;
endpackage : sfcf_pkg
`default_nettype wire

// ### verilog/sfcf_fifo.sv
`timescale 1ns/10ps
`default_nettype none
module sfcf_fifo #(
    parameter int W = 8,
    parameter int D = 8
) (
    input  wire logic         mclk,
    input  wire logic         resetn,
    input  wire logic         clr,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);
    logic [W-1:0]  mem_r [D];
    logic [AW:0]   wp_r;
    logic [AW:0]   rp_r;
    logic          full;
    logic          empty;
    assign full      = (wp_r[AW] != rp_r[AW]) && (wp_r[AW-1:0] == rp_r[AW-1:0]);
    assign empty     = (wp_r == rp_r);
    assign in_ready  = !full;
    assign out_valid = !empty;
    assign out_data  = mem_r[rp_r[AW-1:0]];
    always_ff @(posedge mclk) begin
        if (in_valid && !full) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            wp_r <= '0;
            rp_r <= '0;
        end else if (clr) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            if (in_valid && !full) wp_r <= wp_r + 1'b1;
            if (out_ready && !empty) rp_r <= rp_r + 1'b1;
        end
    end
endmodule : sfcf_fifo
`default_nettype wire

// ### verilog/sfcf_protect.sv
`timescale 1ns/10ps
`default_nettype none
module sfcf_protect
    import sfcf_pkg::*;
(
    input  wire logic        protect_complement,
    input  wire logic        small_granule_protect,
    input  wire logic        top_bottom,
    input  wire logic [2:0]  protect_field,
    input  wire logic [23:0] addr,
    output logic             is_protected
);
    logic [23:0] span;
    logic        in_low;
    always_comb begin
        span         = 24'h000000;
        in_low       = 1'b0;
        is_protected = 1'b0;
        if (!protect_complement) begin
            is_protected = 1'b0;
        end else if (protect_field == 3'h0) begin
            is_protected = 1'b1;
        end else if (protect_field == 3'h7) begin
            is_protected = 1'b0;
        end else if (!small_granule_protect) begin
            span = 24'h040000 << (protect_field - 3'h1);
            if (!top_bottom) is_protected = addr < (24'h000000 - span);
            else is_protected = addr >= span;
        end else begin
            span = 24'h001000 << ((protect_field > 3'h4) ? 3'h3 : protect_field - 3'h1);
            in_low = addr < span;
            if (!top_bottom) is_protected = addr < (24'h000000 - span);
            else is_protected = !in_low;
        end
    end
endmodule : sfcf_protect
`default_nettype wire

// ### dv/sfcf_host.sv
`timescale 1ns/10ps
`default_nettype none
module sfcf_host (
    input  wire logic mclk,
    input  wire logic serial_out,
    input  wire logic serial_out_en,
    output logic      chip_select_n,
    output logic      serial_clk,
    output logic      serial_in
);
    // link clock idles low outside frames
    initial begin
        chip_select_n = 1'h1;
        serial_clk    = 1'h0;
        serial_in     = 1'h0;
    end
    task automatic tick(input int n);
        repeat (n) @(negedge mclk);
    endtask : tick
    task automatic frame_on;
        tick(4);
        chip_select_n = 1'h0;
        tick(4);
    endtask : frame_on
    // select rises only after the last whole bit
    task automatic frame_off;
        tick(4);
        chip_select_n = 1'h1;
        serial_in     = ~serial_in;
        tick(12);
    endtask : frame_off
    // nb bits of b out, read bits gathered into r
    task automatic shift(input logic [7:0] b, input int nb, output logic [7:0] r);
        r = 8'h00;
        for (int i = 7; i > 7 - nb; i--) begin
            serial_in = b[i];
            tick(4);
            serial_clk = 1'h1;
            // undriven line reads as pulled high
            r = {r[6:0], serial_out_en ? serial_out : 1'h1};
            tick(4);
            serial_clk = 1'h0;
        end
    endtask : shift
endmodule : sfcf_host
`default_nettype wire

// ### dv/sfcf_frontend_test.sv
`timescale 1ns/10ps
`default_nettype none
module sfcf_frontend_test
    import sfcf_pkg::*;
();
    logic        mclk, resetn, array_busy, data_ready, op_prev;
    logic        chip_select_n, serial_clk, serial_in, serial_out, serial_out_en;
    logic        op_valid, data_valid, write_enable_latch, powered_down;
    logic [7:0]  param_rdata, op_code, data_byte, status_one, status_two, status_three, s;
    logic [23:0] param_addr, op_addr, a;
    logic [63:0] d;
    logic [31:0] op_q[$];
    logic [7:0]  dat_q[$];
    logic [7:0]  ers[3] = '{OP_SECE, OP_HBLE, OP_BLKE};
    logic [4:0]  pcfg[4] = '{5'h06, 5'h09, 5'h11, 5'h1D};
    logic [23:0] pa[4] = '{24'h100000, 24'h040000, 24'hFFE000, 24'h008000};
    logic [23:0] fa[4] = '{24'h800000, 24'h03F000, 24'hFFF000, 24'h007000};
    int          error_cnt = 0;
    int          tests_run = 0;

    assign param_rdata = param_addr[7:0] ^ 8'hA5;

    initial begin
        mclk = 1'h0;
        forever #50 mclk = ~mclk;
    end

    sfcf_frontend sfcf_frontend_inst (.mclk(mclk), .resetn(resetn),
        .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in),
        .serial_out(serial_out), .serial_out_en(serial_out_en), .array_busy(array_busy),
        .param_rdata(param_rdata), .param_addr(param_addr), .op_valid(op_valid),
        .op_code(op_code), .op_addr(op_addr), .data_valid(data_valid),
        .data_byte(data_byte), .data_ready(data_ready),
        .write_enable_latch(write_enable_latch), .powered_down(powered_down),
        .status_one(status_one), .status_two(status_two), .status_three(status_three));
    sfcf_host sfcf_host_inst (.mclk(mclk), .serial_out(serial_out),
        .serial_out_en(serial_out_en),
        .chip_select_n(chip_select_n), .serial_clk(serial_clk), .serial_in(serial_in));

    task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
        tests_run++;
        if (g !== e) begin
            error_cnt++;
            $display("unexpected at %0t: %s got %0h want %0h", $time, m, g, e);
        end
    endtask : chk
    task automatic send(input logic [127:0] v, input int n);
        logic [7:0] r;
        sfcf_host_inst.frame_on();
        for (int i = n - 1; i >= 0; i--) sfcf_host_inst.shift(v[8*i +: 8], 8, r);
    endtask : send
    task automatic cmd(input logic [127:0] v, input int n, input int tail);
        logic [7:0] r;
        send(v, n);
        if (tail > 0) sfcf_host_inst.shift(8'hA5, tail, r);
        sfcf_host_inst.frame_off();
    endtask : cmd
    task automatic wr(input logic [127:0] v, input int n);
        cmd(OP_WREN, 1, 0);
        cmd(v, n, 0);
    endtask : wr
    task automatic rd(input logic [63:0] v, input int n, input logic [7:0] e0, e1);
        logic [7:0] r;
        send(v, n);
        sfcf_host_inst.shift(8'hFF, 8, r);
        chk(r, e0, "read byte 0");
        sfcf_host_inst.shift(8'hFF, 8, r);
        chk(r, e1, "read byte 1");
        sfcf_host_inst.frame_off();
    endtask : rd
    task automatic done(input string t);
        repeat (40) @(negedge mclk);
        chk(op_q.size() + dat_q.size(), 0, "missing result");
        $display("test %s done", t);
    endtask : done
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish

    // results are matched against the oldest note
    always @(posedge mclk) begin
        op_prev <= op_valid;
        if (op_valid === 1'h1 && op_prev !== 1'h1)
            chk({op_code, op_addr}, op_q.size() ? op_q.pop_front() : 32'hX, "op");
        if (data_valid === 1'h1 && data_ready)
            chk(data_byte, dat_q.size() ? dat_q.pop_front() : 8'hX, "data");
    end

    initial begin
        #6000000;
        error_cnt++;
        $display("unexpected at %0t: watchdog expired", $time);
        tally_and_finish();
    end

    initial begin
        resetn     = 1'h0;
        array_busy = 1'h0;
        data_ready = 1'h1;
        void'($urandom(62));
        repeat (8) @(negedge mclk);
        resetn = 1'h1;
        repeat (3) @(negedge mclk);
        chk({status_one, status_two, status_three}, {SR1_RST, SR2_RST, SR3_RST}, "reset");
        cmd(OP_WREN, 1, 0);
        chk(write_enable_latch, 1'h1, "latch set");
        rd(OP_RDS1, 1, SR1_RST | 8'(1 << SR1_WEL), SR1_RST | 8'(1 << SR1_WEL));
        cmd(OP_WRITE_DISABLE_CMD, 1, 0);
        chk(write_enable_latch, 1'h0, "latch clear");
        cmd(OP_VWREN, 1, 0);
        cmd({OP_SECE, 24'($urandom)}, 4, 0);
        done("latch");
        for (int k = 0; k < 3; k++) begin
            a = 24'($urandom);
            op_q.push_back({ers[k], a});
            wr({ers[k], a}, 4);
            wr({ers[k], a, 8'h00}, 5);
            cmd({ers[k], a}, 4, 3);
        end
        done("erase");
        // stalled sink: fifo takes all eight bytes
        data_ready = 1'h0;
        a = 24'($urandom);
        d = {$urandom, $urandom};
        op_q.push_back({OP_PGM, a});
        for (int i = 7; i >= 0; i--) dat_q.push_back(d[8*i +: 8]);
        wr({OP_PGM, a, d}, 12);
        repeat (20) @(negedge mclk);
        data_ready = 1'h1;
        done("program");
        wr({OP_PGM, a}, 4);
        cmd({OP_PGM, a}, 4, 5);
        cmd({OP_QPGM, a}, 4, 0);
        chk(write_enable_latch, 1'h1, "latch kept");
        done("short program");
        for (int k = 0; k < 4; k++) begin
            s = {2'h0, pcfg[k][3:0], 2'h0};
            wr({OP_WRS1, s, 8'h40, 7'h00, pcfg[k][4]}, 4);
            chk({status_one[5:2], status_two[6], status_three[0]},
                {pcfg[k][3:0], 1'h1, pcfg[k][4]}, "status");
            chk(write_enable_latch, 1'h0, "status write");
            wr({OP_SECE, pa[k]}, 4);
            op_q.push_back({OP_SECE, fa[k]});
            wr({OP_SECE, fa[k]}, 4);
        end
        done("protection");
        wr({OP_WRS2, 8'h00}, 2);
        wr({OP_WRS3A, 8'h01}, 2);
        rd(OP_RDS2A, 1, 8'h00, 8'h00);
        rd(OP_RDS3B, 1, 8'h01, 8'h01);
        wr({OP_WRS3B, 8'h00}, 2);
        wr({OP_WRS2, 8'h40}, 2);
        rd(OP_RDS3A, 1, 8'h00, 8'h00);
        rd(OP_RDS2B, 1, 8'h40, 8'h40);
        cmd(OP_WREN, 1, 0);
        array_busy = 1'h1;
        cmd({OP_SECE, 24'h000000}, 4, 0);
        array_busy = 1'h0;
        chk(write_enable_latch, 1'h1, "busy refused");
        cmd(OP_WRITE_DISABLE_CMD, 1, 0);
        cmd({8'h3E, OP_WREN}, 2, 0);
        chk(write_enable_latch, 1'h0, "unknown opcode");
        done("busy and unknown");
        cmd(OP_DPD, 1, 0);
        cmd({OP_WAKE, 16'h0000}, 3, 0);
        cmd(OP_WREN, 1, 0);
        chk({powered_down, write_enable_latch}, 2'h2, "still asleep");
        rd({OP_WAKE, 24'h000000}, 4, DEV_ID, DEV_ID);
        chk(powered_down, 1'h0, "awake");
        a = 24'($urandom);
        rd({OP_SFDP, a, 8'h00}, 5, a[7:0] ^ 8'hA5, 8'(a + 1) ^ 8'hA5);
        done("wake and parameters");
        tally_and_finish();
    end
endmodule : sfcf_frontend_test
`default_nettype wire
